// file: src/cable_diagnostic_control.sv
/*
 * Control and status for the reflectometry cable test of the second copper port.
 * Assumes the analog engine pulses tdrDone with a valid result, and that the
 * link partner shutdown logic reports partnerQuiet as a synchronous level.
 */
`timescale 1ns/1ps

module cable_diagnostic_control (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   // switch register access
   input  wire logic [7:0]                  regAddr,
   input  wire logic                        regWrite,
   input  wire logic [7:0]                  regWdata,
   input  wire logic                        regRead,
   output logic      [7:0]                  regRdata,
   // management register access
   input  wire logic [4:0]                  phyAddr,
   input  wire logic                        phyWrite,
   input  wire logic [15:0]                 phyWdata,
   input  wire logic                        phyRead,
   output logic      [15:0]                 phyRdata,
   // media and analog engine
   input  wire logic                        fiberMode,
   input  wire logic                        partnerQuiet,
   input  wire logic                        tdrDone,
   input  wire cable_diag_pkg::tdr_result_t tdrResult,
   output logic                             quietRequest,
   output logic                             tdrStart,
   output logic                             mdixManual
);

   cable_diag_pkg::diag_state_t state,     next_state;
   cable_diag_pkg::tdr_result_t result,    next_result;
   logic [cable_diag_pkg::CNT_W-1:0] count,     next_count;
   logic [7:0]                       portCtrl,  next_portCtrl;
   logic [7:0]                       next_regRdata;
   logic [15:0]                      next_phyRdata;
   logic                             next_quietRequest;
   logic                             next_tdrStart;
   logic                             busy;
   logic                             startReq;

   localparam logic [cable_diag_pkg::CNT_W-1:0] QUIET_LAST =
      cable_diag_pkg::CNT_W'(cable_diag_pkg::QUIET_CYCLES - 1);
   localparam logic [cable_diag_pkg::CNT_W-1:0] MEAS_LAST =
      cable_diag_pkg::CNT_W'(cable_diag_pkg::MEAS_CYCLES - 1);

   assign busy     = (state != cable_diag_pkg::ST_IDLE);
   assign mdixManual = portCtrl[cable_diag_pkg::CTRL_MDIX_BIT];

   // both register paths may start the test
   assign startReq = (regWrite && regAddr == cable_diag_pkg::REG_CTRL_STATUS
                      && regWdata[cable_diag_pkg::CS_START_BIT])
                  || (phyWrite && phyAddr == cable_diag_pkg::PHY_CABLE_TEST
                      && phyWdata[cable_diag_pkg::PHY_START_BIT]);

   function automatic logic [7:0] readByte(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         cable_diag_pkg::REG_CTRL_STATUS: begin
            d[cable_diag_pkg::CS_RESULT_LSB +: 2] = result.code;
            d[cable_diag_pkg::CS_START_BIT]       = busy;
            d[cable_diag_pkg::CS_DIST_MSB]        = result.distance[8];
         end
         cable_diag_pkg::REG_DISTANCE_LOW:  d = result.distance[7:0];
         cable_diag_pkg::REG_PORT_TWO_CTRL: d = portCtrl;
         default:                           d = 8'h00;
      endcase
      return d;
   endfunction : readByte

   function automatic logic [15:0] readWord(input logic [4:0] a);
      logic [15:0] d;
      d = 16'h0000;
      unique case (a)
         cable_diag_pkg::PHY_BASIC_CTRL:
            d[cable_diag_pkg::PHY_MDIX_BIT] = portCtrl[cable_diag_pkg::CTRL_MDIX_BIT];
         cable_diag_pkg::PHY_CABLE_TEST: begin
            d[cable_diag_pkg::PHY_START_BIT]       = busy;
            d[cable_diag_pkg::PHY_RESULT_LSB +: 2] = result.code;
            d[8:0]                                 = result.distance;
         end
         default: d = 16'h0000;
      endcase
      return d;
   endfunction : readWord

   always_comb begin
      next_state        = state;
      next_result       = result;
      next_count        = count;
      next_portCtrl     = portCtrl;
      next_quietRequest = quietRequest;
      next_tdrStart     = 1'b0;
      next_regRdata     = regRead ? readByte(regAddr) : regRdata;
      next_phyRdata     = phyRead ? readWord(phyAddr) : phyRdata;

      // crossover control from either path, switch path wins on collision
      if (phyWrite && phyAddr == cable_diag_pkg::PHY_BASIC_CTRL)
         next_portCtrl[cable_diag_pkg::CTRL_MDIX_BIT] =
            phyWdata[cable_diag_pkg::PHY_MDIX_BIT];
      if (regWrite && regAddr == cable_diag_pkg::REG_PORT_TWO_CTRL)
         next_portCtrl = regWdata;

      unique case (state)
         cable_diag_pkg::ST_IDLE: begin
            // results are left untouched here until a new start
            if (startReq) begin
               if (fiberMode) begin
                  next_result.code     = cable_diag_pkg::RES_INVALID;
                  next_result.distance = 9'h000;
               end else begin
                  next_state        = cable_diag_pkg::ST_QUIET;
                  next_quietRequest = 1'b1;
                  next_count        = '0;
               end
            end
         end
         cable_diag_pkg::ST_QUIET: begin
            if (partnerQuiet) begin
               next_state    = cable_diag_pkg::ST_MEASURE;
               next_tdrStart = 1'b1;
               next_count    = '0;
            end else if (count == QUIET_LAST) begin
               // own echo cannot be told from foreign signal, so no pulse
               next_state           = cable_diag_pkg::ST_IDLE;
               next_quietRequest    = 1'b0;
               next_result.code     = cable_diag_pkg::RES_INVALID;
               next_result.distance = 9'h000;
            end else begin
               next_count = count + 1'b1;
            end
         end
         cable_diag_pkg::ST_MEASURE: begin
            if (tdrDone) begin
               next_state        = cable_diag_pkg::ST_IDLE;
               next_quietRequest = 1'b0;
               next_result       = tdrResult;
            end else if (count == MEAS_LAST) begin
               // engine never answered; do not hang the busy bit
               next_state           = cable_diag_pkg::ST_IDLE;
               next_quietRequest    = 1'b0;
               next_result.code     = cable_diag_pkg::RES_INVALID;
               next_result.distance = 9'h000;
            end else begin
               next_count = count + 1'b1;
            end
         end
         default: begin
            next_state        = cable_diag_pkg::ST_IDLE;
            next_quietRequest = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state        <= cable_diag_pkg::ST_IDLE;
         result       <= '0;
         count        <= '0;
         portCtrl     <= cable_diag_pkg::PORT_TWO_CTRL_RESET;
         regRdata     <= 8'h00;
         phyRdata     <= 16'h0000;
         quietRequest <= 1'b0;
         tdrStart     <= 1'b0;
      end else begin
         state        <= next_state;
         result       <= next_result;
         count        <= next_count;
         portCtrl     <= next_portCtrl;
         regRdata     <= next_regRdata;
         phyRdata     <= next_phyRdata;
         quietRequest <= next_quietRequest;
         tdrStart     <= next_tdrStart;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_launch;
      tdrStart ##1 (!tdrStart && state == cable_diag_pkg::ST_MEASURE);
   endsequence

   chk_start_sets_busy: assert property (
      (state == cable_diag_pkg::ST_IDLE && startReq && !fiberMode)
      |=> (busy && quietRequest))
      else $error("start did not raise busy");
   chk_fiber_invalid: assert property (
      (state == cable_diag_pkg::ST_IDLE && startReq && fiberMode)
      |=> (!busy && result.code == cable_diag_pkg::RES_INVALID))
      else $error("fiber start not reported invalid");
   chk_quiet_launch: assert property (
      (state == cable_diag_pkg::ST_QUIET && partnerQuiet) |=> s_launch)
      else $error("measurement pulse not issued once");
   chk_no_pulse_noisy: assert property (
      (state == cable_diag_pkg::ST_QUIET && !partnerQuiet && count == QUIET_LAST)
      |=> (!busy && !tdrStart && result.code == cable_diag_pkg::RES_INVALID))
      else $error("unsilenced partner not reported invalid");
   chk_result_capture: assert property (
      (state == cable_diag_pkg::ST_MEASURE && tdrDone)
      |=> (!busy && result == $past(tdrResult) && !quietRequest))
      else $error("result not captured on completion");
   chk_result_hold: assert property (
      (state == cable_diag_pkg::ST_IDLE && !startReq) |=> $stable(result))
      else $error("result changed without a new start");
   chk_status_read: assert property (
      (regRead && regAddr == cable_diag_pkg::REG_CTRL_STATUS)
      |=> (regRdata[cable_diag_pkg::CS_START_BIT] == $past(busy)
           && regRdata[cable_diag_pkg::CS_DIST_MSB] == $past(result.distance[8])))
      else $error("status byte read wrong");
   chk_mdix_write: assert property (
      (regWrite && regAddr == cable_diag_pkg::REG_PORT_TWO_CTRL)
      |=> mdixManual == $past(regWdata[cable_diag_pkg::CTRL_MDIX_BIT]))
      else $error("crossover control not written");
   chk_phy_read: assert property (
      (phyRead && phyAddr == cable_diag_pkg::PHY_CABLE_TEST)
      |=> (phyRdata[8:0] == $past(result.distance)
           && phyRdata[cable_diag_pkg::PHY_START_BIT] == $past(busy)))
      else $error("management read of results wrong");

endmodule : cable_diagnostic_control

// file: src/cable_diag_pkg.sv
/*
 * Constants, field layout and types for the copper cable diagnostic control block.
 * Assumes a single 25 MHz system clock and byte-wide switch register access.
 */
package cable_diag_pkg;

   // switch register map, byte addresses
   localparam logic [7:0] REG_CTRL_STATUS   = 8'h2A;
   localparam logic [7:0] REG_DISTANCE_LOW  = 8'h2B;
   localparam logic [7:0] REG_PORT_TWO_CTRL = 8'h2D;

   // cable_test_ctrl_status and port two control fields
   localparam int CS_START_BIT   = 4;
   localparam int CS_RESULT_LSB  = 5;
   localparam int CS_DIST_MSB    = 0;
   localparam int CTRL_MDIX_BIT  = 2;
   localparam logic [7:0] PORT_TWO_CTRL_RESET = 8'h00;

   // management register map and fields
   localparam logic [4:0] PHY_BASIC_CTRL = 5'h00;
   localparam logic [4:0] PHY_CABLE_TEST = 5'h1D;
   localparam int PHY_MDIX_BIT     = 5;
   localparam int PHY_START_BIT    = 15;
   localparam int PHY_RESULT_LSB   = 13;

   // outcome codes
   localparam logic [1:0] RES_NORMAL  = 2'h0;
   localparam logic [1:0] RES_OPEN    = 2'h1;
   localparam logic [1:0] RES_SHORT   = 2'h2;
   localparam logic [1:0] RES_INVALID = 2'h3;

   // timing
   localparam int CLK_PERIOD_NS    = 40;
   localparam int QUIET_TIMEOUT_NS = 10000;
   localparam int MEAS_TIMEOUT_NS  = 100000;
   localparam int QUIET_CYCLES = (QUIET_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1
                                 : QUIET_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int MEAS_CYCLES  = (MEAS_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1
                                 : MEAS_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   typedef struct packed {
      logic [1:0] code;
      logic [8:0] distance;
   } tdr_result_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_QUIET   = 3'b010,
      ST_MEASURE = 3'b100
   } diag_state_t;

endpackage : cable_diag_pkg

// file: verification/tb_cable_diagnostic_control.sv
/* self-checking testbench for cable_diagnostic_control: register-level tests
   through the switch and management ports.
   assumes the block alone, a 40 ns clock, and the bench acting as the engine. */
`timescale 1ns/1ps
module tb_cable_diagnostic_control;
   logic                        sysClk       = 1'b0;
   logic                        rst          = 1'b1;
   logic [7:0]                  regAddr      = 8'h00;
   logic [7:0]                  regWdata     = 8'h00;
   logic                        regWrite     = 1'b0;
   logic                        regRead      = 1'b0;
   logic [7:0]                  regRdata;
   logic [4:0]                  phyAddr      = 5'h00;
   logic [15:0]                 phyWdata     = 16'h0000;
   logic                        phyWrite     = 1'b0;
   logic                        phyRead      = 1'b0;
   logic [15:0]                 phyRdata;
   logic                        fiberMode    = 1'b0;
   logic                        partnerQuiet = 1'b1;
   logic                        tdrDone      = 1'b0;
   cable_diag_pkg::tdr_result_t tdrResult    = '0;
   logic                        quietRequest;
   logic                        tdrStart;
   logic                        mdixManual;
   logic [15:0]                 rdVal;
   logic                        distHigh     = 1'b0;
   // software scale in tenths of a meter per count; recalibrate for odd cable
   localparam int               SCALE_TENTHS = 4;
   int                          err_total    = 0;
   int                          checked      = 0;
   int                          starts       = 0;

   always #20 sysClk = ~sysClk;
   always @(posedge sysClk) if (tdrStart === 1'b1) starts <= starts + 1;

   cable_diagnostic_control i_cable_diagnostic_control (
      .sys_clk(sysClk), .rst(rst),
      .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
      .regRead(regRead), .regRdata(regRdata),
      .phyAddr(phyAddr), .phyWrite(phyWrite), .phyWdata(phyWdata),
      .phyRead(phyRead), .phyRdata(phyRdata),
      .fiberMode(fiberMode), .partnerQuiet(partnerQuiet), .tdrDone(tdrDone),
      .tdrResult(tdrResult), .quietRequest(quietRequest), .tdrStart(tdrStart),
      .mdixManual(mdixManual));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one access; read data is taken two edges on, after it has settled
   task acc(input bit phy, input bit w, input logic [7:0] a, input logic [15:0] d);
      @(negedge sysClk);
      if (phy) begin
         phyAddr = a[4:0];
         phyWdata = d;
         phyWrite = w;
         phyRead = !w;
      end else begin
         regAddr = a;
         regWdata = d[7:0];
         regWrite = w;
         regRead = !w;
      end
      @(negedge sysClk);
      {phyWrite, phyRead, regWrite, regRead} = 4'h0;
      @(negedge sysClk);
      rdVal = phy ? phyRdata : {8'h00, regRdata};
   endtask : acc

   task rd(input bit phy, input logic [7:0] a, input logic [15:0] e,
           input logic [15:0] m = 16'hFFFF);
      acc(phy, 1'b0, a, 16'h0000);
      chk(rdVal & m, e);
   endtask : rd

   // start, act as engine if a measurement is launched, poll until idle
   task runTest(input bit phy, input logic [1:0] c, input logic [8:0] d, input int nStart);
      int n;
      n = starts;
      acc(phy, 1'b1, phy ? 8'h1D : 8'h2A, phy ? 16'h8000 : 16'h0010);
      if (!fiberMode) begin
         rd(phy, phy ? 8'h1D : 8'h2A, phy ? 16'h8000 : 16'h0010, phy ? 16'h8000 : 16'h0010);
         chk({15'h0, quietRequest}, 16'h0001);
      end
      for (int i = 0; i < 20 && starts == n; i++) @(negedge sysClk);
      if (starts != n) begin
         tdrResult = {c, d};
         tdrDone = 1'b1;
         @(negedge sysClk);
         tdrDone = 1'b0;
      end
      for (int i = 0; i < 400; i++) begin
         acc(phy, 1'b0, phy ? 8'h1D : 8'h2A, 16'h0000);
         if ((phy ? rdVal[15] : rdVal[4]) === 1'b0) break;
      end
      chk(16'(starts - n), 16'(nStart));
      chk({15'h0, quietRequest}, 16'h0000);
   endtask : runTest

   task finish_test;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test

   // longest path is the measurement timeout; a few thousand cycles suffice
   initial begin
      #(40 * 20000);
      err_total++;
      finish_test();
   end

   initial begin
      repeat (12) @(negedge sysClk);
      rst = 1'b0;
      rd(0, 8'h2A, 16'h0000);
      rd(0, 8'h2B, 16'h0000);
      rd(0, 8'h2D, 16'h0000);
      rd(0, 8'h40, 16'h0000);
      rd(1, 8'h00, 16'h0000);
      rd(1, 8'h1D, 16'h0000);
      chk({15'h0, mdixManual}, 16'h0000);
      $display("test reset values done");
      acc(0, 1'b1, 8'h2D, 16'h0004);
      chk({15'h0, mdixManual}, 16'h0001);
      rd(1, 8'h00, 16'h0020, 16'h0020);
      acc(1, 1'b1, 8'h00, 16'h0000);
      rd(0, 8'h2D, 16'h0000, 16'h0004);
      acc(0, 1'b1, 8'h2D, 16'h0004);
      $display("test crossover control done");
      for (int c = 0; c < 3; c++) begin
         runTest(0, 2'(c), 9'h1A5 ^ 9'(c), 1);
         rd(0, 8'h2A, {9'h0, 2'(c), 4'h0, 1'b1});
         distHigh = rdVal[0];
         rd(0, 8'h2B, 16'h00A5 ^ 16'(c));
         chk(16'(({distHigh, rdVal[7:0]} * SCALE_TENTHS) / 10), 16'(((9'h1A5 ^ 9'(c)) * SCALE_TENTHS) / 10));
      end
      $display("test outcome codes done");
      acc(0, 1'b1, 8'h2A, 16'h006F);
      acc(0, 1'b1, 8'h2B, 16'h00FF);
      rd(0, 8'h2A, 16'h0041);
      rd(0, 8'h2B, 16'h00A7);
      $display("test read-only results done");
      runTest(1, 2'h2, 9'h0C3, 1);
      rd(1, 8'h1D, 16'h40C3, 16'hE1FF);
      rd(0, 8'h2B, 16'h00C3);
      $display("test management path done");
      partnerQuiet = 1'b0;
      runTest(0, 2'h0, 9'h000, 0);
      rd(0, 8'h2A, 16'h0060);
      rd(0, 8'h2B, 16'h0000);
      $display("test partner not silenced done");
      partnerQuiet = 1'b1;
      // engine never answers: busy must hold, then drop with code 11
      acc(0, 1'b1, 8'h2A, 16'h0010);
      repeat (2400) @(negedge sysClk);
      rd(0, 8'h2A, 16'h0010, 16'h0010);
      repeat (200) @(negedge sysClk);
      rd(0, 8'h2A, 16'h0060);
      chk({15'h0, quietRequest}, 16'h0000);
      $display("test engine timeout done");
      runTest(0, 2'h1, 9'h011, 1);
      fiberMode = 1'b1;
      runTest(0, 2'h0, 9'h000, 0);
      rd(0, 8'h2A, 16'h0060);
      $display("test fiber refusal done");
      finish_test();
   end
endmodule : tb_cable_diagnostic_control
